/* File: inc/phy_config_consts.svh */
// offsets, field positions and fixed field values of the configuration block
`ifndef PHY_CONFIG_CONSTS_SVH
`define PHY_CONFIG_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_CONTROL 5'h00
`define IDX_ADVERT 5'h04
`define IDX_PARTNER 5'h05
`define IDX_VENDOR 5'h11
`define IDX_STATUS 5'h1F

// control register fields
`define CTRL_SOFT_RESET_BIT 15
`define CTRL_POWER_DOWN_BIT 11
// advertisement register fields
`define ADV_PAUSE_BIT 10
`define ADV_ABILITY_LSB 5
`define ADV_SELECTOR 5'h01
// partner ability register fields
`define PARTNER_PAUSE_BIT 10
// vendor control register fields
`define VC_REPEATER_BIT 15
`define VC_LINK_SAVE_BIT 12
`define VC_ANALOG_OFF_BIT 11

// an all-zero strapped address means power down
`define PHY_ADDR_POWER_DOWN 5'h00

// AHB encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

/* File: inc/phy_config_pkg.sv */
// types shared by the configuration block
package phy_config_pkg;

  typedef struct packed {
    logic fiber;
    logic serial;
    logic autoneg;
    logic parallelDetect;
    logic speed100;
    logic full;
    logic [3:0] ability;
  } mode_type;

  typedef struct packed {
    logic [4:0] phyAddress;
    logic fiberStrap;
    logic interfaceStrap;
    logic autonegStrap;
    logic speedStrap;
    logic duplexStrap;
    logic repeaterStrap;
    logic linkSaveStrap;
    logic isolateStrap;
  } strap_type;

endpackage

/* File: design/strap_resolver.sv */
// turns latched strap levels into the operating mode
`timescale 1ns/1ps
`include "phy_config_consts.svh"

module strap_resolver
  import phy_config_pkg::*;
(
  input wire strap_type straps,
  output mode_type mode
);

  always_comb begin
    mode.fiber = straps.fiberStrap;
    // fiber wins over the interface select strap
    mode.serial = !straps.fiberStrap && !straps.interfaceStrap;
    // serial and fiber ignore the autoneg and speed straps
    mode.autoneg = !mode.fiber && !mode.serial && straps.autonegStrap;
    mode.parallelDetect = !mode.fiber && !mode.serial && !straps.autonegStrap;
    if (mode.fiber) begin
      mode.speed100 = 1'b1;
    end else if (mode.serial) begin
      mode.speed100 = 1'b0;
    end else begin
      mode.speed100 = straps.speedStrap;
    end
    mode.full = straps.duplexStrap;
    // ability order: 100 full, 100 half, 10 full, 10 half
    if (mode.autoneg) begin
      mode.ability = {straps.speedStrap && straps.duplexStrap, straps.speedStrap,
                      straps.duplexStrap, 1'b1};
    end else begin
      mode.ability = {mode.speed100 && mode.full, mode.speed100 && !mode.full,
                      !mode.speed100 && mode.full, !mode.speed100 && !mode.full};
    end
  end

endmodule

/* File: design/led_driver.sv */
// applies per-pin polarity to the five indicator functions
`timescale 1ns/1ps

module led_driver #(
  parameter int LED_COUNT = 5
) (
  input wire logic [LED_COUNT-1:0] lit,
  input wire logic [LED_COUNT-1:0] strappedHigh,
  output logic [LED_COUNT-1:0] level
);

  genvar i;
  generate
    for (i = 0; i < LED_COUNT; i++) begin : gen_led
      // strapped high means the pin sinks current to light the lamp
      assign level[i] = strappedHigh[i] ? !lit[i] : lit[i];
    end
  endgenerate

endmodule

/* File: design/phy_strap_config_power_modes.sv */
// strap resolution, power modes, indicators and register slave of the transceiver
// How it works
// - serial interface runs 10Mbps only, ignores autoneg and speed; duplex strap sets duplex.
// - fiber runs 100Base-FX only, ignores autoneg and speed; duplex strap sets duplex.
// - advertisement bit 10 set by software adds flow control to the advertisement.
// - partner flow control ability shows in bit 10 of register 5.
// - isolate strap high cuts the MAC and management access, minimum power.
// - repeater strap high selects repeater mode; low keeps adapter mode unless register 17 bit 15 is set.
// - link-down saving entered by register 17 bit 12 or its strap.
// - saving with link off sends only NLP-like pulses until receive energy.
// - interface select high gives MII, low gives serial interface at 10Mbps.
// - autoneg strap high enables autonegotiation, low gives parallel detection.
// - speed strap sets advertised speed, or forces speed without autonegotiation.
// - duplex strap sets advertised duplex, or forces duplex without autonegotiation.
// - each LED pin polarity follows its strapped address level, high gives active low.
// - five LEDs show link, full duplex, 10 activity, 100 activity, collision.
// - register 17 bit 11 powers analog off, digital logic stays alive.
// - register 0 bit 11 powers everything down except the management access.
// - address straps latched during reset; all-zero address means power down.
// - register 17 bit 15 also selects repeater mode.
// - reset clears registers, disconnects the media and restarts negotiation.
`timescale 1ns/1ps
`include "phy_config_consts.svh"

module phy_strap_config_power_modes
  import phy_config_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_WIDTH-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // straps
  input wire logic fiberSelectStrap,
  input wire logic interfaceSelectStrap,
  input wire logic autonegEnableStrap,
  input wire logic speedStrap,
  input wire logic duplexStrap,
  input wire logic repeaterStrap,
  input wire logic linkDownPowerSavingStrap,
  input wire logic isolateStrap,
  // shared address strap / LED pins, index 0 link .. 4 collision
  input wire logic [4:0] phyAddressStrap,
  output logic [4:0] ledDrive,
  output logic [4:0] ledDriveOe,
  // link state from the media side
  input wire logic linkUp,
  input wire logic linkFullDuplex,
  input wire logic activity10,
  input wire logic activity100,
  input wire logic collision,
  input wire logic rxEnergy,
  input wire logic [15:0] partnerAbility,
  input wire logic partnerValid,
  // resolved configuration and power controls
  output logic fiberMode,
  output logic serialMode,
  output logic autonegEnable,
  output logic parallelDetect,
  output logic speed100,
  output logic fullDuplex,
  output logic [3:0] advertiseAbility,
  output logic advertisePause,
  output logic repeaterMode,
  output logic analogEnable,
  output logic digitalEnable,
  output logic macIsolate,
  output logic txQuiet,
  output logic mediaConnect,
  output logic restartAutoneg
);

  typedef struct packed {
    strap_type straps;
    logic powerDown;
    logic advPause;
    logic [15:0] partner;
    logic vcRepeater;
    logic vcLinkSave;
    logic vcAnalogOff;
    logic wakeSeen;
    logic linkWas;
    logic restartPending;
    logic wrPending;
    logic [4:0] wrIndex;
    logic readyOut;
    logic [31:0] readData;
    logic [4:0] ledLevel;
    logic [4:0] ledOe;
    logic fiber;
    logic serial;
    logic autoneg;
    logic pd;
    logic spd100;
    logic full;
    logic [3:0] ability;
    logic repeater;
    logic analogOn;
    logic digitalOn;
    logic isolate;
    logic quiet;
    logic connect;
    logic restart;
  } state_type;

  state_type state_reg;
  state_type state_next;
  mode_type mode;
  logic [4:0] ledLevel;
  logic [4:0] ledLit;

  strap_resolver resolver (
    .straps(state_reg.straps),
    .mode(mode)
  );

  led_driver #(
    .LED_COUNT(5)
  ) leds (
    .lit(ledLit),
    .strappedHigh(state_reg.straps.phyAddress),
    .level(ledLevel)
  );

  // whether a byte address falls on one of the five mapped registers
  function automatic logic addrMapped(input logic [ADDR_WIDTH-1:0] a);
    logic [4:0] idx;
    idx = a[6:2];
    addrMapped = (a[ADDR_WIDTH-1:7] == '0) &&
                 (idx == `IDX_CONTROL || idx == `IDX_ADVERT || idx == `IDX_PARTNER ||
                  idx == `IDX_VENDOR || idx == `IDX_STATUS);
  endfunction

  logic powerDownEffective;
  logic linkSaveActive;
  logic addrPhase;
  logic [15:0] readWord;
  logic [4:0] rdIndex;

  always_comb begin
    state_next = state_reg;
    // straps are only watched while reset is held
    state_next.restart = 1'b0;
    // an all-zero strapped address is treated as a power-down request
    powerDownEffective = state_reg.powerDown ||
                         (state_reg.straps.phyAddress == `PHY_ADDR_POWER_DOWN);
    linkSaveActive = state_reg.vcLinkSave || state_reg.straps.linkSaveStrap;
    addrPhase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
    rdIndex = haddr[6:2];
    readWord = 16'h0000;

    // data phase of a write: isolation blocks management writes
    if (state_reg.wrPending && !state_reg.straps.isolateStrap) begin
      unique case (state_reg.wrIndex)
        `IDX_CONTROL: begin
          state_next.powerDown = hwdata[`CTRL_POWER_DOWN_BIT];
          if (hwdata[`CTRL_SOFT_RESET_BIT]) begin
            // soft reset clears software state but keeps the latched straps
            state_next.powerDown = 1'b0;
            state_next.advPause = 1'b0;
            state_next.partner = 16'h0000;
            state_next.vcRepeater = 1'b0;
            state_next.vcLinkSave = 1'b0;
            state_next.vcAnalogOff = 1'b0;
            state_next.restartPending = 1'b1;
          end
        end
        `IDX_ADVERT: state_next.advPause = hwdata[`ADV_PAUSE_BIT];
        `IDX_VENDOR: begin
          state_next.vcRepeater = hwdata[`VC_REPEATER_BIT];
          state_next.vcLinkSave = hwdata[`VC_LINK_SAVE_BIT];
          state_next.vcAnalogOff = hwdata[`VC_ANALOG_OFF_BIT];
        end
        default: ;
      endcase
    end

    // partner ability captured as received; a capture wins over a soft reset clear
    if (partnerValid) begin
      state_next.partner = partnerAbility;
    end

    // reads of registers 0, 4, 5 and 17 see this cycle's write so back-to-back write then read is coherent; the status word shows registered state
    unique case (rdIndex)
      `IDX_CONTROL: begin
        readWord[`CTRL_POWER_DOWN_BIT] = state_next.powerDown;
      end
      `IDX_ADVERT: begin
        readWord[`ADV_PAUSE_BIT] = state_next.advPause;
        readWord[`ADV_ABILITY_LSB+:4] = mode.ability;
        readWord[4:0] = `ADV_SELECTOR;
      end
      `IDX_PARTNER: readWord = state_next.partner;
      `IDX_VENDOR: begin
        readWord[`VC_REPEATER_BIT] = state_next.vcRepeater;
        readWord[`VC_LINK_SAVE_BIT] = state_next.vcLinkSave;
        readWord[`VC_ANALOG_OFF_BIT] = state_next.vcAnalogOff;
      end
      `IDX_STATUS: begin
        readWord = {state_reg.quiet, powerDownEffective, state_reg.repeater, mode.fiber,
                    mode.serial, mode.autoneg, mode.speed100, mode.full,
                    3'h0, state_reg.straps.phyAddress};
      end
      default: readWord = 16'h0000;
    endcase

    state_next.wrPending = addrPhase && hwrite && addrMapped(haddr);
    state_next.wrIndex = rdIndex;
    if (addrPhase && !hwrite) begin
      // isolated: the management port answers nothing useful
      state_next.readData = (addrMapped(haddr) && !state_reg.straps.isolateStrap) ?
                            {16'h0000, readWord} : 32'h00000000;
    end
    state_next.readyOut = 1'b1;

    // link-down saving: quiet once the link is lost, wake on receive energy
    state_next.linkWas = linkUp;
    if (!linkSaveActive || (linkUp && !state_reg.linkWas)) begin
      state_next.wakeSeen = 1'b0;
    end else if (rxEnergy) begin
      state_next.wakeSeen = 1'b1;
    end
    state_next.quiet = linkSaveActive && !linkUp && !state_next.wakeSeen;

    // registered copy of the resolved mode
    state_next.fiber = mode.fiber;
    state_next.serial = mode.serial;
    state_next.autoneg = mode.autoneg;
    state_next.pd = mode.parallelDetect;
    state_next.spd100 = mode.speed100;
    state_next.full = mode.full;
    state_next.ability = mode.ability;
    state_next.repeater = state_reg.straps.repeaterStrap || state_next.vcRepeater;

    // power domains
    state_next.isolate = state_reg.straps.isolateStrap;
    state_next.digitalOn = !powerDownEffective && !state_reg.straps.isolateStrap;
    state_next.analogOn = state_next.digitalOn && !state_next.vcAnalogOff;

    // media stays off for the cycle in which negotiation restarts
    state_next.connect = !state_next.restartPending && state_next.analogOn;
    if (state_reg.restartPending) begin
      state_next.restart = 1'b1;
      state_next.restartPending = 1'b0;
    end

    // indicators go dark with the digital logic
    state_next.ledLevel = ledLevel;
    state_next.ledOe = 5'h1F;

    // hold reset: straps follow the pins until release, lamps off the pins
    if (!reset_n) begin
      state_next = '0;
      state_next.straps = {phyAddressStrap, fiberSelectStrap, interfaceSelectStrap,
                           autonegEnableStrap, speedStrap, duplexStrap, repeaterStrap,
                           linkDownPowerSavingStrap, isolateStrap};
      state_next.restartPending = 1'b1;
      state_next.readyOut = 1'b1;
    end
  end

  always_comb begin
    ledLit = 5'h00;
    if (state_reg.digitalOn) begin
      ledLit[0] = linkUp;
      ledLit[1] = linkUp && linkFullDuplex;
      ledLit[2] = linkUp && activity10;
      ledLit[3] = linkUp && activity100;
      ledLit[4] = collision;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign hreadyout = state_reg.readyOut;
  assign hresp = `HRESP_OKAY;
  assign hrdata = state_reg.readData;
  assign ledDrive = state_reg.ledLevel;
  assign ledDriveOe = state_reg.ledOe;
  assign fiberMode = state_reg.fiber;
  assign serialMode = state_reg.serial;
  assign autonegEnable = state_reg.autoneg;
  assign parallelDetect = state_reg.pd;
  assign speed100 = state_reg.spd100;
  assign fullDuplex = state_reg.full;
  assign advertiseAbility = state_reg.ability;
  assign advertisePause = state_reg.advPause;
  assign repeaterMode = state_reg.repeater;
  assign analogEnable = state_reg.analogOn;
  assign digitalEnable = state_reg.digitalOn;
  assign macIsolate = state_reg.isolate;
  assign txQuiet = state_reg.quiet;
  assign mediaConnect = state_reg.connect;
  assign restartAutoneg = state_reg.restart;

endmodule

/* File: verification/phy_config_monitor.sv */
// concurrent checks on the strap, power and indicator outputs
`timescale 1ns/1ps
module phy_config_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic [4:0] phyAddressStrap,
  input wire logic linkUp,
  input wire logic rxEnergy,
  input wire logic [4:0] ledDrive,
  input wire logic [4:0] ledDriveOe,
  input wire logic fiberMode,
  input wire logic serialMode,
  input wire logic autonegEnable,
  input wire logic parallelDetect,
  input wire logic speed100,
  input wire logic txQuiet,
  input wire logic macIsolate,
  input wire logic analogEnable,
  input wire logic digitalEnable,
  input wire logic restartAutoneg,
  input wire logic mediaConnect
);
  // own copy of the address straps, since the pins turn into LED outputs
  logic [4:0] strapSeen;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strapSeen <= phyAddressStrap;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  serial_slow_a: assert property (serialMode |-> !speed100)
    else $error("serial mode at 100");
  fiber_fast_a: assert property (fiberMode |-> speed100 && !serialMode)
    else $error("fiber mode not 100");
  parallel_detect_a: assert property ($past(reset_n) && !fiberMode && !serialMode
    |-> parallelDetect != autonegEnable) else $error("parallel detect wrong");
  led_enable_a: assert property ($past(reset_n) |-> ledDriveOe == 5'h1F)
    else $error("led not driven");
  led_link_a: assert property ($past(reset_n) && $past(digitalEnable) && digitalEnable
    |-> ledDrive[0] == ($past(linkUp) ^ strapSeen[0])) else $error("link led level");
  quiet_link_a: assert property (txQuiet |-> !$past(linkUp))
    else $error("quiet with link");
  energy_wake_a: assert property (rxEnergy |-> ##[1:3] !txQuiet)
    else $error("no wake on energy");
  isolate_read_a: assert property (macIsolate && hsel && hready && htrans[1] && !hwrite
    |=> hrdata == 32'h0) else $error("isolated read data");
  isolate_power_a: assert property (macIsolate |-> !analogEnable && !digitalEnable)
    else $error("isolated but powered");
  restart_pulse_a: assert property (restartAutoneg |=> !restartAutoneg)
    else $error("restart not a pulse");
  media_hold_a: assert property ($rose(reset_n) |-> !mediaConnect [*2])
    else $error("media connected early");
endmodule
bind phy_strap_config_power_modes phy_config_monitor mon_i (.clk, .reset_n, .hsel, .hready,
  .htrans, .hwrite, .hrdata, .phyAddressStrap, .linkUp, .rxEnergy, .ledDrive, .ledDriveOe,
  .fiberMode, .serialMode, .autonegEnable, .parallelDetect, .speed100, .txQuiet, .macIsolate,
  .analogEnable, .digitalEnable, .restartAutoneg, .mediaConnect);

/* File: verification/mac_model.sv */
// bus master standing in for the MAC's register accesses
`timescale 1ns/1ps
module mac_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end
  // besides a hardware reset no other wake path exists, so leaving power-down by software goes through here
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule

/* File: verification/tb.sv */
// self-checking bench for strap resolution, power modes and indicators
`timescale 1ns/1ps
`include "phy_config_consts.svh"
module tb;
  import phy_config_pkg::*;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdv;
  strap_type st;
  logic linkUp, linkFullDuplex, activity10, activity100, collision, rxEnergy, partnerValid;
  logic [15:0] partnerAbility;
  logic [4:0] ledDrive, ledDriveOe;
  logic fiberMode, serialMode, autonegEnable, parallelDetect, speed100, fullDuplex;
  logic [3:0] advertiseAbility;
  logic advertisePause, repeaterMode, analogEnable, digitalEnable, macIsolate, txQuiet;
  logic mediaConnect, restartAutoneg;
  int err_count = 0;
  int n_compared = 0;
  phy_strap_config_power_modes phy_strap_config_power_modes_i (.clk, .reset_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .fiberSelectStrap(st.fiberStrap), .interfaceSelectStrap(st.interfaceStrap),
    .autonegEnableStrap(st.autonegStrap), .speedStrap(st.speedStrap),
    .duplexStrap(st.duplexStrap), .repeaterStrap(st.repeaterStrap),
    .linkDownPowerSavingStrap(st.linkSaveStrap), .isolateStrap(st.isolateStrap),
    .phyAddressStrap(st.phyAddress), .ledDrive, .ledDriveOe, .linkUp, .linkFullDuplex,
    .activity10, .activity100, .collision, .rxEnergy, .partnerAbility, .partnerValid,
    .fiberMode, .serialMode, .autonegEnable, .parallelDetect, .speed100, .fullDuplex,
    .advertiseAbility, .advertisePause, .repeaterMode, .analogEnable, .digitalEnable,
    .macIsolate, .txQuiet, .mediaConnect, .restartAutoneg);
  mac_model mac_model_i (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic strap_type base();
    strap_type s;
    s = '0;
    s.phyAddress = 5'h15;
    s.interfaceStrap = 1'b1;
    s.autonegStrap = 1'b1;
    s.speedStrap = 1'b1;
    s.duplexStrap = 1'b1;
    return s;
  endfunction
  function automatic logic [11:0] ad(input logic [4:0] i);
    return {5'h00, i, 2'b00};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // the extra nanosecond lets the edge's register updates land before sampling
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst(input strap_type s);
    @(posedge clk);
    st <= s;
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wt(3);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    mac_model_i.xfer(1'b1, a, d, rdv);
    wt(2);
  endtask
  task automatic rd(input logic [11:0] a);
    mac_model_i.xfer(1'b0, a, 32'h0, rdv);
  endtask
  task automatic t_modes();
    strap_type s;
    logic [3:0] ab;
    for (int i = 0; i < 12; i++) begin
      s = base();
      {s.autonegStrap, s.speedStrap, s.duplexStrap} = i[2:0];
      if (i > 7) begin
        {s.fiberStrap, s.interfaceStrap} = {i[1], 1'b0};
        {s.autonegStrap, s.speedStrap} = {~i[1], ~i[1]};
      end
      rst(s);
      ab = {s.speedStrap & s.duplexStrap, s.speedStrap, s.duplexStrap, 1'b1};
      chk("fiber mode", s.fiberStrap, fiberMode);
      chk("serial mode", !s.fiberStrap && !s.interfaceStrap, serialMode);
      if (i > 7) begin
        chk("fixed speed", s.fiberStrap, speed100);
        chk("fixed duplex", s.duplexStrap, fullDuplex);
        chk("autoneg ignored", 1'b0, autonegEnable);
      end else begin
        chk("autoneg", s.autonegStrap, autonegEnable);
        chk("parallel detect", !s.autonegStrap, parallelDetect);
        if (s.autonegStrap) begin
          chk("ability", ab, advertiseAbility);
        end else begin
          chk("forced speed", s.speedStrap, speed100);
          chk("forced duplex", s.duplexStrap, fullDuplex);
        end
      end
    end
    $display("test modes done");
  endtask
  task automatic t_regs();
    strap_type s;
    rst(base());
    chk("repeater", 1'b0, repeaterMode);
    wr(ad(`IDX_ADVERT), 32'h00000400);
    chk("pause", 1'b1, advertisePause);
    rd(ad(`IDX_ADVERT));
    chk("advert word", 32'h000005E1, rdv);
    @(posedge clk);
    partnerAbility <= 16'h0421;
    partnerValid <= 1'b1;
    @(posedge clk);
    partnerValid <= 1'b0;
    partnerAbility <= 16'hBBDE;
    rd(ad(`IDX_PARTNER));
    chk("partner word", 32'h00000421, rdv);
    rd(12'h020);
    chk("unmapped", 32'h0, rdv);
    wr(ad(`IDX_VENDOR), 32'h00008000);
    chk("repeater sw", 1'b1, repeaterMode);
    wr(ad(`IDX_CONTROL), 32'h00008000);
    rd(ad(`IDX_VENDOR));
    chk("vendor after reset", 32'h0, rdv);
    chk("repeater cleared", 1'b0, repeaterMode);
    s = base();
    s.repeaterStrap = 1'b1;
    rst(s);
    chk("repeater strap", 1'b1, repeaterMode);
    $display("test registers done");
  endtask
  task automatic t_power();
    strap_type s;
    rst(base());
    wr(ad(`IDX_VENDOR), 32'h00000800);
    chk("analog off", 1'b0, analogEnable);
    chk("digital alive", 1'b1, digitalEnable);
    wr(ad(`IDX_VENDOR), 32'h0);
    chk("analog back", 1'b1, analogEnable);
    wr(ad(`IDX_CONTROL), 32'h00000800);
    chk("digital down", 1'b0, digitalEnable);
    chk("analog down", 1'b0, analogEnable);
    rd(ad(`IDX_CONTROL));
    chk("control word", 32'h00000800, rdv);
    chk("response", `HRESP_OKAY, hresp);
    wr(ad(`IDX_CONTROL), 32'h0);
    chk("woken", 1'b1, digitalEnable);
    s = base();
    s.phyAddress = `PHY_ADDR_POWER_DOWN;
    rst(s);
    chk("zero address", 1'b0, digitalEnable);
    rd(ad(`IDX_STATUS));
    chk("status word", 32'h00004700, rdv);
    $display("test power done");
  endtask
  task automatic t_link_save();
    strap_type s;
    rst(base());
    wr(ad(`IDX_VENDOR), 32'h00001000);
    chk("quiet", 1'b1, txQuiet);
    @(posedge clk);
    rxEnergy <= 1'b1;
    @(posedge clk);
    rxEnergy <= 1'b0;
    wt(3);
    chk("woken by energy", 1'b0, txQuiet);
    @(posedge clk);
    linkUp <= 1'b1;
    repeat (2) @(posedge clk);
    linkUp <= 1'b0;
    wt(3);
    chk("quiet again", 1'b1, txQuiet);
    wr(ad(`IDX_VENDOR), 32'h0);
    chk("saving off", 1'b0, txQuiet);
    s = base();
    s.linkSaveStrap = 1'b1;
    rst(s);
    chk("strap quiet", 1'b1, txQuiet);
    $display("test link saving done");
  endtask
  task automatic t_isolate();
    strap_type s;
    s = base();
    s.isolateStrap = 1'b1;
    rst(s);
    chk("isolated", 1'b1, macIsolate);
    wr(ad(`IDX_VENDOR), 32'h00008000);
    rd(ad(`IDX_VENDOR));
    chk("isolated read", 32'h0, rdv);
    chk("isolated write", 1'b0, repeaterMode);
    $display("test isolate done");
  endtask
  task automatic t_led();
    rst(base());
    @(posedge clk);
    {collision, activity100, activity10, linkFullDuplex, linkUp} <= 5'h1F;
    wt(2);
    chk("leds lit", 5'h0A, ledDrive);
    @(posedge clk);
    {collision, activity100, activity10, linkFullDuplex, linkUp} <= 5'h00;
    st.phyAddress <= 5'h0A;
    st.fiberStrap <= 1'b1;
    wt(2);
    chk("leds dark", 5'h15, ledDrive);
    chk("mode held", 1'b0, fiberMode);
    $display("test leds done");
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    st = base();
    {linkUp, linkFullDuplex, activity10, activity100, collision, rxEnergy} = 6'h00;
    partnerAbility = 16'h0000;
    partnerValid = 1'b0;
    t_modes();
    t_regs();
    t_power();
    t_link_save();
    t_isolate();
    t_led();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
